/* core/hssw_regs.svh */
// Register offsets, field positions, reset values and timing counts of the load switch block.
`ifndef HSSW_REGS_SVH
`define HSSW_REGS_SVH
`define HSSW_ADDR_SEL_A     8'h00
`define HSSW_ADDR_SEL_B     8'h04
`define HSSW_ADDR_SUP_CFG   8'h08
`define HSSW_ADDR_OC_STAT   8'h0c
`define HSSW_ADDR_OL_STAT   8'h10
`define HSSW_ADDR_SUP_STAT  8'h14
`define HSSW_ADDR_DUTY1     8'h18
`define HSSW_ADDR_DUTY2     8'h1c
`define HSSW_ADDR_FREQ      8'h20
`define HSSW_SEL_STRIDE     4
`define HSSW_OV_DIS_BIT     0
`define HSSW_UV_DIS_BIT     1
`define HSSW_REC_EN_BIT     2
`define HSSW_OV_FLAG_BIT    0
`define HSSW_UV_FLAG_BIT    1
`define HSSW_RST_SEL        3'h0
`define HSSW_RST_SUP_CFG    3'h0
`define HSSW_RST_DUTY       8'h00
`define HSSW_RST_FREQ       2'h0
`define HSSW_CLK_HZ         25000000
`define HSSW_CLK_NS         40
`define HSSW_OC_FILT_US     16
`define HSSW_OL_FILT_US     64
`define HSSW_OC_FILT_CYC    ((`HSSW_OC_FILT_US * 1000 + `HSSW_CLK_NS - 1) / `HSSW_CLK_NS)
`define HSSW_OL_FILT_CYC    ((`HSSW_OL_FILT_US * 1000 + `HSSW_CLK_NS - 1) / `HSSW_CLK_NS)
`define HSSW_PWM_LO_HZ      200
`define HSSW_PWM_HI_HZ      400
`define HSSW_PWM_LO_CYC     (`HSSW_CLK_HZ / `HSSW_PWM_LO_HZ)
`define HSSW_PWM_HI_CYC     (`HSSW_CLK_HZ / `HSSW_PWM_HI_HZ)
`endif

/* core/hssw_pkg.sv */
// Types shared by the load switch block.
package hssw_pkg;
	typedef enum logic [2:0] {
		HSSW_SRC_OFF  = 3'h0,
		HSSW_SRC_ON   = 3'h1,
		HSSW_SRC_TMR1 = 3'h2,
		HSSW_SRC_TMR2 = 3'h3,
		HSSW_SRC_PWM1 = 3'h4,
		HSSW_SRC_PWM2 = 3'h5
	} hssw_src_t;
	typedef enum logic [2:0] {
		HSSW_MODE_NORMAL   = 3'h0,
		HSSW_MODE_STOP     = 3'h1,
		HSSW_MODE_SLEEP    = 3'h2,
		HSSW_MODE_RESTART  = 3'h3,
		HSSW_MODE_FAILSAFE = 3'h4
	} hssw_mode_t;
	typedef enum logic [1:0] {
		HSSW_SUP_OK    = 2'b01,
		HSSW_SUP_FAULT = 2'b10
	} hssw_sup_t;
endpackage

/* core/hssw_ctrl.sv */
// Control of four high-side load switches with APB registers, PWM generators and protection.
//
// Overview of operation
// - Each output follows one chosen source: software on/off, a timer, or a PWM generator.
// - Configuration is writable only in normal mode; kept and locked in stop and sleep.
// - All outputs go off while the system is in restart or fail-safe mode.
// - Supply overvoltage forces outputs off unless overvoltage shutdown is disabled.
// - Supply undervoltage forces outputs off unless undervoltage shutdown is disabled.
// - After a supply fault, recovery resumes outputs; otherwise outputs stay off, fields cleared.
// - Supply faults set only the supply overvoltage and undervoltage flags.
// - Overcurrent lasting longer than the 16 us filter switches the output off.
// - Overcurrent shutdown sets the output's flag and resets its configuration to 000.
// - Overcurrent flags stay set until software clears them.
// - Open load checked only while on; low current for 64 us sets the flag.
// - Open load leaves the output on; its flag stays until software clears it.
// - Protection stays active in stop and sleep modes.
// - Outputs may stay on or PWM driven in low-power modes if configured earlier.
// - After restart or fail-safe, outputs can be re-enabled by register writes.
// - Two PWM generators each have their own 8-bit duty register.
// - Each generator runs at 200 Hz or 400 Hz, chosen independently.
// - A generator's waveform appears as soon as an output selects it.
// - Each output can select timer 1, timer 2, PWM 1, PWM 2, on or off.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "hssw_regs.svh"

module hssw_ctrl
	import hssw_pkg::*;
#(
	parameter int unsigned OC_CYC    = `HSSW_OC_FILT_CYC,
	parameter int unsigned OL_CYC    = `HSSW_OL_FILT_CYC,
	parameter int unsigned PWM_LO_CYC = `HSSW_PWM_LO_CYC,
	parameter int unsigned PWM_HI_CYC = `HSSW_PWM_HI_CYC
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// System mode and timers.
	input  hssw_mode_t       sys_mode_i,
	input  wire logic        timer1_i,
	input  wire logic        timer2_i,
	// Analog comparators.
	input  wire logic        supply_ov_i,
	input  wire logic        supply_uv_i,
	input  wire logic [3:0]  overcurrent_i,
	input  wire logic [3:0]  openload_i,
	// Switch drive.
	output logic      [3:0]  load_switch_output_o
);
	localparam int PW  = $clog2(PWM_LO_CYC + 1);
	localparam int OCW = $clog2(OC_CYC + 1);
	localparam int OLW = $clog2(OL_CYC + 1);

	logic [9:0]    sync1_r;
	logic [9:0]    sync2_r;
	logic          ov_s;
	logic          uv_s;
	logic [3:0]    oc_s;
	logic [3:0]    ol_s;
	hssw_src_t     cfg_r [4];
	logic [2:0]    sup_cfg_r;
	logic [7:0]    duty_r [2];
	logic [1:0]    freq_r;
	logic [3:0]    oc_flag_r;
	logic [3:0]    ol_flag_r;
	logic [1:0]    sup_flag_r;
	logic [3:0]    out_r;
	logic [1:0]    pwm_lvl;
	logic [3:0]    oc_trip;
	logic [3:0]    ol_trip;
	hssw_sup_t     sup_st_r;
	logic          sup_fault;
	logic          sup_clear;
	logic          normal;
	logic          mode_off;
	logic          setup;
	logic          wr;
	logic          cfg_addr;
	logic          mapped;
	logic [31:0]   rd_data;
	logic [31:0]   prdata_r;
	logic          pready_r;
	logic          pslverr_r;
	logic          wr_sel_a;
	logic          wr_sel_b;
	logic          wr_sup_cfg;
	logic          wr_duty1;
	logic          wr_duty2;
	logic          wr_freq;
	logic          wr_oc_stat;
	logic          wr_ol_stat;
	logic          wr_sup_stat;
	logic [3:0]    oc_clr;
	logic [3:0]    ol_clr;
	logic [1:0]    sup_clr;
	logic          out_block;

	// Level picked by a source code; spare codes read as off.
	function automatic logic src_level(input hssw_src_t s, input logic t1, input logic t2,
			input logic [1:0] p);
		logic lvl;
		lvl = 1'b0;
		unique case (s)
			HSSW_SRC_ON:   lvl = 1'b1;
			HSSW_SRC_TMR1: lvl = t1;
			HSSW_SRC_TMR2: lvl = t2;
			HSSW_SRC_PWM1: lvl = p[0];
			HSSW_SRC_PWM2: lvl = p[1];
			default:       lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	// Comparator inputs are asynchronous to clk_i.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_r <= 10'h000;
			sync2_r <= 10'h000;
		end else begin
			sync1_r <= {openload_i, overcurrent_i, supply_uv_i, supply_ov_i};
			sync2_r <= sync1_r;
		end
	end
	assign ov_s = sync2_r[0];
	assign uv_s = sync2_r[1];
	assign oc_s = sync2_r[5:2];
	assign ol_s = sync2_r[9:6];

	assign normal   = (sys_mode_i == HSSW_MODE_NORMAL);
	assign mode_off = (sys_mode_i == HSSW_MODE_RESTART) || (sys_mode_i == HSSW_MODE_FAILSAFE);
	assign sup_fault = (ov_s && !sup_cfg_r[`HSSW_OV_DIS_BIT])
		|| (uv_s && !sup_cfg_r[`HSSW_UV_DIS_BIT]);

	// APB decode. Zero wait states: the answer is prepared in the setup cycle.
	assign setup = psel_i && !penable_i;
	assign wr    = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;
	assign cfg_addr = (paddr_i == `HSSW_ADDR_SEL_A) || (paddr_i == `HSSW_ADDR_SEL_B)
		|| (paddr_i == `HSSW_ADDR_SUP_CFG) || (paddr_i == `HSSW_ADDR_DUTY1)
		|| (paddr_i == `HSSW_ADDR_DUTY2) || (paddr_i == `HSSW_ADDR_FREQ);
	assign mapped = cfg_addr || (paddr_i == `HSSW_ADDR_OC_STAT)
		|| (paddr_i == `HSSW_ADDR_OL_STAT) || (paddr_i == `HSSW_ADDR_SUP_STAT);

	// One write strobe per register, so every store below sees a single enable.
	assign wr_sel_a    = wr && (paddr_i == `HSSW_ADDR_SEL_A);
	assign wr_sel_b    = wr && (paddr_i == `HSSW_ADDR_SEL_B);
	assign wr_sup_cfg  = wr && (paddr_i == `HSSW_ADDR_SUP_CFG);
	assign wr_duty1    = wr && (paddr_i == `HSSW_ADDR_DUTY1);
	assign wr_duty2    = wr && (paddr_i == `HSSW_ADDR_DUTY2);
	assign wr_freq     = wr && (paddr_i == `HSSW_ADDR_FREQ);
	assign wr_oc_stat  = wr && (paddr_i == `HSSW_ADDR_OC_STAT);
	assign wr_ol_stat  = wr && (paddr_i == `HSSW_ADDR_OL_STAT);
	assign wr_sup_stat = wr && (paddr_i == `HSSW_ADDR_SUP_STAT);
	assign oc_clr      = wr_oc_stat ? pwdata_i[3:0] : 4'h0;
	assign ol_clr      = wr_ol_stat ? pwdata_i[3:0] : 4'h0;
	assign sup_clr     = wr_sup_stat ? pwdata_i[1:0] : 2'h0;

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr_i)
			`HSSW_ADDR_SEL_A:    rd_data = {25'h0, cfg_r[1], 1'b0, cfg_r[0]};
			`HSSW_ADDR_SEL_B:    rd_data = {25'h0, cfg_r[3], 1'b0, cfg_r[2]};
			`HSSW_ADDR_SUP_CFG:  rd_data = {29'h0, sup_cfg_r};
			`HSSW_ADDR_OC_STAT:  rd_data = {28'h0, oc_flag_r};
			`HSSW_ADDR_OL_STAT:  rd_data = {28'h0, ol_flag_r};
			`HSSW_ADDR_SUP_STAT: rd_data = {30'h0, sup_flag_r};
			`HSSW_ADDR_DUTY1:    rd_data = {24'h0, duty_r[0]};
			`HSSW_ADDR_DUTY2:    rd_data = {24'h0, duty_r[1]};
			`HSSW_ADDR_FREQ:     rd_data = {30'h0, freq_r};
			default:             rd_data = 32'h0000_0000;
		endcase
	end

	// A configuration write outside normal mode is refused with an error answer.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			prdata_r  <= (setup && !pwrite_i) ? rd_data : 32'h0000_0000;
			pslverr_r <= setup && (!mapped || (pwrite_i && cfg_addr && !normal));
		end
	end

	// Supply fault tracking; the leaving edge decides recovery.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sup_st_r <= HSSW_SUP_OK;
		end else begin
			unique case (sup_st_r)
				HSSW_SUP_OK:    if (sup_fault) sup_st_r <= HSSW_SUP_FAULT;
				HSSW_SUP_FAULT: if (!sup_fault) sup_st_r <= HSSW_SUP_OK;
			endcase
		end
	end
	assign sup_clear = (sup_st_r == HSSW_SUP_FAULT) && !sup_fault
		&& !sup_cfg_r[`HSSW_REC_EN_BIT];
	// The cycle in which a fault leaves without recovery is blocked too, since the selects clear only at its end.
	assign out_block = mode_off || sup_fault || sup_clear;

	// Source selection. Hardware clears win over a write in the same cycle.
	generate
		for (genvar i = 0; i < 4; i++) begin : g_cfg
			localparam bit LOW_PAIR = (i < 2);
			localparam int LSB = (i % 2) * `HSSW_SEL_STRIDE;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cfg_r[i] <= hssw_src_t'(`HSSW_RST_SEL);
				end else if (mode_off) begin
					cfg_r[i] <= HSSW_SRC_OFF;
				end else if (oc_trip[i] || sup_clear) begin
					cfg_r[i] <= HSSW_SRC_OFF;
				end else if (LOW_PAIR ? wr_sel_a : wr_sel_b) begin
					cfg_r[i] <= hssw_src_t'(pwdata_i[LSB +: 3]);
				end
			end
		end
	endgenerate

	// Settings that only change by software writes; kept as is in low-power modes.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sup_cfg_r <= `HSSW_RST_SUP_CFG;
			duty_r[0] <= `HSSW_RST_DUTY;
			duty_r[1] <= `HSSW_RST_DUTY;
			freq_r    <= `HSSW_RST_FREQ;
		end else begin
			if (wr_sup_cfg)
				sup_cfg_r <= pwdata_i[2:0];
			if (wr_duty1)
				duty_r[0] <= pwdata_i[7:0];
			if (wr_duty2)
				duty_r[1] <= pwdata_i[7:0];
			if (wr_freq)
				freq_r <= pwdata_i[1:0];
		end
	end

	// PWM generators run freely so a newly assigned output picks up the wave at once.
	generate
		for (genvar g = 0; g < 2; g++) begin : g_pwm
			logic [PW-1:0]   cnt_r;
			logic [PW-1:0]   per;
			logic [PW+7:0]   prod;
			logic [PW-1:0]   thr_r;
			logic            lvl_r;
			assign per  = freq_r[g] ? PW'(PWM_HI_CYC) : PW'(PWM_LO_CYC);
			assign prod = (PW+8)'(duty_r[g]) * (PW+8)'(per);
			// The threshold is registered to keep the multiplier off the compare path.
			// A new duty therefore reaches the wave one cycle later; a new frequency sets the period at once and the threshold one cycle later.
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					thr_r <= '0;
				end else begin
					thr_r <= prod[PW+7:8];
				end
			end
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cnt_r <= '0;
					lvl_r <= 1'b0;
				end else begin
					cnt_r <= (cnt_r >= per - PW'(1)) ? '0 : cnt_r + PW'(1);
					lvl_r <= (cnt_r < thr_r);
				end
			end
			assign pwm_lvl[g] = lvl_r;
		end
	endgenerate

	// Per output drive and load monitoring; both filters need the condition unbroken.
	generate
		for (genvar i = 0; i < 4; i++) begin : g_out
			logic [OCW-1:0] oc_cnt_r;
			logic [OLW-1:0] ol_cnt_r;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					out_r[i] <= 1'b0;
				end else begin
					out_r[i] <= !out_block
						&& src_level(cfg_r[i], timer1_i, timer2_i, pwm_lvl);
				end
			end
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					oc_cnt_r <= '0;
				end else if (out_r[i] && oc_s[i] && !oc_trip[i]) begin
					oc_cnt_r <= oc_cnt_r + OCW'(1);
				end else begin
					oc_cnt_r <= '0;
				end
			end
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ol_cnt_r <= '0;
				end else if (out_r[i] && ol_s[i] && ol_cnt_r != OLW'(OL_CYC)) begin
					ol_cnt_r <= ol_cnt_r + OLW'(1);
				end else if (!(out_r[i] && ol_s[i])) begin
					ol_cnt_r <= '0;
				end
			end
			assign oc_trip[i] = out_r[i] && oc_s[i] && (oc_cnt_r == OCW'(OC_CYC));
			assign ol_trip[i] = out_r[i] && ol_s[i] && (ol_cnt_r == OLW'(OL_CYC - 1));
		end
	endgenerate

	// Sticky flags, write one to clear; a new event in the clearing cycle wins.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oc_flag_r <= 4'h0;
		end else begin
			oc_flag_r <= oc_trip | (oc_flag_r & ~oc_clr);
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ol_flag_r <= 4'h0;
		end else begin
			ol_flag_r <= ol_trip | (ol_flag_r & ~ol_clr);
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sup_flag_r <= 2'h0;
		end else begin
			sup_flag_r <= {uv_s, ov_s} | (sup_flag_r & ~sup_clr);
		end
	end

	assign prdata_o             = prdata_r;
	assign pready_o             = pready_r;
	assign pslverr_o            = pslverr_r;
	assign load_switch_output_o = out_r;
endmodule

/* test/hssw_load_model.sv */
// Behavioural model of the four loads on the switch outputs.
`timescale 1ns/1ps
module hssw_load_model (
	// Switch drive seen at the loads.
	input  wire logic [3:0] drive_i,
	// Faults placed on each load by the bench.
	input  wire logic [3:0] short_i,
	input  wire logic [3:0] open_i,
	// Current comparator levels back to the block.
	output logic      [3:0] overcurrent_o,
	output logic      [3:0] openload_o
);
	// A load draws current only while its switch is on, so both levels drop with the drive.
	assign overcurrent_o = drive_i & short_i;
	assign openload_o    = drive_i & open_i;
endmodule

/* test/hssw_ctrl_sva.sv */
// Port assertions of the load switch controller.
`timescale 1ns/1ps
module hssw_ctrl_sva import hssw_pkg::*; #(parameter int unsigned OC_CYC = 8) (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// APB slave.
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Mode, supply, current and drive.
	input hssw_mode_t       sys_mode_i,
	input wire logic        supply_ov_i,
	input wire logic        supply_uv_i,
	input wire logic [3:0]  overcurrent_i,
	input wire logic [3:0]  load_switch_output_o
);
	localparam int OC_MAX = OC_CYC + 8;
	logic       wr_ok;
	logic [2:0] cfg_r;
	assign wr_ok = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;
	// The supply settings are internal, so a shadow copy follows every accepted write.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_r <= 3'h0;
		end else if (wr_ok && paddr_i == 8'h08) begin
			cfg_r <= pwdata_i[2:0];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("pready is not one cycle after setup");
	a_lock_err: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h00
		&& sys_mode_i != HSSW_MODE_NORMAL |-> pslverr_o) else $error("locked write not refused");
	a_sel_on: assert property (wr_ok && paddr_i == 8'h00 && pwdata_i[2:0] == 3'h1 && !supply_ov_i
		&& !supply_uv_i && overcurrent_i == 4'h0 |-> ##2 load_switch_output_o[0])
		else $error("selected on source not driven");
	a_mode_off: assert property ((sys_mode_i inside {HSSW_MODE_RESTART, HSSW_MODE_FAILSAFE})[*3]
		|-> load_switch_output_o == 4'h0) else $error("output on in restart or fail-safe");
	a_ov_off: assert property ((supply_ov_i && !cfg_r[0])[*5] |-> load_switch_output_o == 4'h0)
		else $error("output on during overvoltage");
	a_uv_off: assert property ((supply_uv_i && !cfg_r[1])[*5] |-> load_switch_output_o == 4'h0)
		else $error("output on during undervoltage");
	a_no_resume: assert property ($fell(supply_uv_i) && !supply_ov_i && cfg_r[2:1] == 2'b00
		|-> (load_switch_output_o == 4'h0)[*6]) else $error("output resumed without recovery");
	a_oc_trip: assert property (overcurrent_i[0] && load_switch_output_o[0]
		|-> ##[1:OC_MAX] !load_switch_output_o[0]) else $error("overcurrent did not switch off");
	c_lock: cover property (pready_o && pslverr_o);
	c_trip: cover property (overcurrent_i[0] ##1 !load_switch_output_o[0]);
	c_pwm: cover property ($rose(load_switch_output_o[1]));
endmodule
bind hssw_ctrl hssw_ctrl_sva #(.OC_CYC(OC_CYC)) i_hssw_ctrl_sva (.clk_i, .rst_n_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .sys_mode_i, .supply_ov_i, .supply_uv_i,
	.overcurrent_i, .load_switch_output_o);

/* test/tb.sv */
// Self-checking bench of the load switch controller.
`timescale 1ns/1ps
module tb import hssw_pkg::*;;
	localparam int OC = 8, OL = 16, LO = 512, HI = 256;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic        timer1_i = 1'b0, timer2_i = 1'b0, supply_ov_i = 1'b0, supply_uv_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic        pready_o, pslverr_o;
	logic [3:0]  overcurrent_i, openload_i, lso, short_r = 4'h0, open_r = 4'h0;
	hssw_mode_t  sys_mode_i = HSSW_MODE_NORMAL;
	int          err_total = 0, samples_checked = 0;
	hssw_ctrl #(.OC_CYC(OC), .OL_CYC(OL), .PWM_LO_CYC(LO), .PWM_HI_CYC(HI)) i_hssw_ctrl (.clk_i, .rst_n_i,
		.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sys_mode_i,
		.timer1_i, .timer2_i, .supply_ov_i, .supply_uv_i, .overcurrent_i, .openload_i,
		.load_switch_output_o(lso));
	hssw_load_model i_hssw_load_model (.drive_i(lso), .short_i(short_r), .open_i(open_r),
		.overcurrent_o(overcurrent_i), .openload_o(openload_i));
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic co(input logic [3:0] x);
		chk("out", {28'h0, x}, {28'h0, lso});
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] x);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		chk(w ? "err" : "rdata", x, w ? {31'h0, pslverr_o} : prdata_o);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		acc(a, 1'b1, d, {31'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		acc(a, 1'b0, 32'h0, x);
	endtask
	// Measures one whole high pulse; a waveform that never rises is cut short by the watchdog.
	task automatic pulse(input int b, input int x);
		int n;
		n = 0;
		while (lso[b] !== 1'b0)
			@(posedge clk_i);
		while (lso[b] !== 1'b1)
			@(posedge clk_i);
		while (lso[b] === 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		chk("pulse", 32'(x), 32'(n));
	endtask
	task automatic t_src();
		rd(8'h20, 32'h0);
		wr(8'h24, 32'h0, 1'b1);
		wr(8'h00, 32'h1, 1'b0);
		wr(8'h04, 32'h32, 1'b0);
		timer1_i <= 1'b1;
		cyc(3);
		co(4'h5);
		timer1_i <= 1'b0;
		timer2_i <= 1'b1;
		cyc(3);
		co(4'h9);
		wr(8'h04, 32'h0, 1'b0);
	endtask
	task automatic t_pwm();
		wr(8'h18, 32'h80, 1'b0);
		wr(8'h1c, 32'h40, 1'b0);
		wr(8'h20, 32'h1, 1'b0);
		wr(8'h00, 32'h54, 1'b0);
		pulse(0, HI / 2);
		pulse(1, LO / 4);
		// Both rates swap; the wait lets a period cut short by the change run out first.
		wr(8'h20, 32'h2, 1'b0);
		rd(8'h20, 32'h2);
		cyc(LO);
		pulse(0, LO / 2);
		pulse(1, HI / 4);
	endtask
	task automatic t_mode();
		sys_mode_i <= HSSW_MODE_STOP;
		cyc(2);
		wr(8'h00, 32'h1, 1'b1);
		rd(8'h00, 32'h54);
		pulse(0, LO / 2);
		for (int m = 3; m < 5; m++) begin
			sys_mode_i <= hssw_mode_t'(m[2:0]);
			cyc(3);
			co(4'h0);
			sys_mode_i <= HSSW_MODE_NORMAL;
			wr(8'h00, 32'h1, 1'b0);
			cyc(2);
			co(4'h1);
		end
	endtask
	task automatic t_supply();
		wr(8'h08, 32'h4, 1'b0);
		supply_ov_i <= 1'b1;
		cyc(6);
		co(4'h0);
		supply_ov_i <= 1'b0;
		cyc(6);
		co(4'h1);
		wr(8'h08, 32'h1, 1'b0);
		supply_ov_i <= 1'b1;
		cyc(6);
		co(4'h1);
		supply_ov_i <= 1'b0;
		supply_uv_i <= 1'b1;
		cyc(6);
		co(4'h0);
		supply_uv_i <= 1'b0;
		cyc(6);
		co(4'h0);
		rd(8'h00, 32'h0);
		rd(8'h14, 32'h3);
		rd(8'h0c, 32'h0);
		wr(8'h14, 32'h3, 1'b0);
	endtask
	task automatic t_oc();
		wr(8'h00, 32'h1, 1'b0);
		sys_mode_i <= HSSW_MODE_SLEEP;
		short_r <= 4'h1;
		cyc(OC);
		co(4'h1);
		cyc(6);
		co(4'h0);
		short_r <= 4'h0;
		sys_mode_i <= HSSW_MODE_NORMAL;
		rd(8'h00, 32'h0);
		rd(8'h0c, 32'h1);
		wr(8'h0c, 32'h1, 1'b0);
		rd(8'h0c, 32'h0);
	endtask
	task automatic t_ol();
		wr(8'h00, 32'h10, 1'b0);
		open_r <= 4'h2;
		cyc(OL + 6);
		co(4'h2);
		rd(8'h10, 32'h2);
		wr(8'h00, 32'h0, 1'b0);
		wr(8'h10, 32'h2, 1'b0);
		cyc(OL + 6);
		rd(8'h10, 32'h0);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// The tests need well under ten thousand cycles; this bound allows several times that.
	initial begin
		#1600000;
		err_total++;
		final_report();
	end
	initial begin
		cyc(5);
		rst_n_i <= 1'b1;
		cyc(1);
		t_src();
		t_pwm();
		t_mode();
		t_supply();
		t_oc();
		t_ol();
		final_report();
	end
endmodule
